// ==== logic/boot_page_write_protect.sv ====
// Purpose: Boot flash page write-protect control register with key unlock, APB slave
// Assumes: Single clock, synchronous active-high reset, flash sequencer asks per operation
// Notes: Key register resets the unlock window after any control write
// What this block does
// - Lower unlock bit 15 set allows lower page changes; clear freezes them.
// - Lower unlock bit only clears by write; any reset sets it.
// - Upper unlock bit 7 set allows upper page changes; clear freezes them.
// - Upper unlock bit only clears by write; any reset sets it.
// - Lower bits 8..12 each protect one 16 KB lower alias page.
// - Page bits change only right after key unlock and with unlock bit set.
// - Writes to the control register without key sequence are ignored.
// - Bit 6 reserved for tools, resets to 1, software cannot alter.
// - Bits 31..16, 14, 13 and 5 read zero and ignore writes.
`timescale 1ns/10ps
module boot_page_write_protect #(
  parameter int PAGES = boot_protect_pkg::PAGES_PER_ALIAS
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  input wire logic flash_op_valid_in,
  input wire logic [31:0] flash_op_addr_in,
  output logic flash_op_allow_out,
  output logic flash_op_refuse_out,
  output logic [PAGES-1:0] lower_page_protect_out,
  output logic [PAGES-1:0] upper_page_protect_out
);
  logic lower_alias_unlock_reg;
  logic upper_alias_unlock_reg;
  logic [PAGES-1:0] lower_page_protect_reg;
  logic [PAGES-1:0] upper_page_protect_reg;
  boot_protect_pkg::key_state_type key_state_reg;
  logic [31:0] prdata_reg;
  logic refused_reg;
  logic blocked;
  logic wr_access;
  logic rd_access;
  logic ctrl_write;
  logic ctrl_unlocked;
  boot_protect_pkg::protect_map_type map;

  // Access strobes: zero-wait APB, every access completes in its access phase
  assign wr_access = psel_in && penable_in && pwrite_in && clk_en_in;
  assign rd_access = psel_in && penable_in && !pwrite_in && clk_en_in;
  assign ctrl_write = wr_access && paddr_in == boot_protect_pkg::PROTECT_CTRL_OFFSET;
  assign ctrl_unlocked = key_state_reg == boot_protect_pkg::KEY_OPEN;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign prdata_out = prdata_reg;

  // Composes the control register read image
  function automatic logic [31:0] ctrl_image(input logic lu, input logic uu,
                                             input logic [PAGES-1:0] lp, input logic [PAGES-1:0] up);
    logic [31:0] v;
    v = 32'h00000000;
    v[boot_protect_pkg::LOWER_UNLOCK_BIT] = lu;
    v[boot_protect_pkg::UPPER_UNLOCK_BIT] = uu;
    v[boot_protect_pkg::TOOL_RESERVED_BIT] = 1'b1;
    v[boot_protect_pkg::LOWER_PAGE_LSB +: PAGES] = lp;
    v[boot_protect_pkg::UPPER_PAGE_LSB +: PAGES] = up;
    return v;
  endfunction

  // Key unlock sequencer: two key words in a row open one control write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      key_state_reg <= boot_protect_pkg::KEY_IDLE;
    end else if (wr_access) begin
      case (key_state_reg)
        boot_protect_pkg::KEY_IDLE: begin
          if (paddr_in == boot_protect_pkg::KEY_OFFSET && pwdata_in == boot_protect_pkg::KEY_WORD_FIRST) begin
            key_state_reg <= boot_protect_pkg::KEY_HALF;
          end
        end
        boot_protect_pkg::KEY_HALF: begin
          if (paddr_in == boot_protect_pkg::KEY_OFFSET && pwdata_in == boot_protect_pkg::KEY_WORD_SECOND) begin
            key_state_reg <= boot_protect_pkg::KEY_OPEN;
          end else begin
            key_state_reg <= boot_protect_pkg::KEY_IDLE;
          end
        end
        boot_protect_pkg::KEY_OPEN: begin
          key_state_reg <= boot_protect_pkg::KEY_IDLE; // Any write consumes the window
        end
        default: begin
          key_state_reg <= boot_protect_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // Unlock bits: reset sets them, an unlocked write can only clear them
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lower_alias_unlock_reg <= 1'b1;
      upper_alias_unlock_reg <= 1'b1;
    end else if (ctrl_write && ctrl_unlocked) begin
      lower_alias_unlock_reg <= lower_alias_unlock_reg & pwdata_in[boot_protect_pkg::LOWER_UNLOCK_BIT];
      upper_alias_unlock_reg <= upper_alias_unlock_reg & pwdata_in[boot_protect_pkg::UPPER_UNLOCK_BIT];
    end
  end

  // Page protect bits: need the key window and the old unlock bit still set
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lower_page_protect_reg <= boot_protect_pkg::PAGE_RESET[PAGES-1:0];
      upper_page_protect_reg <= boot_protect_pkg::PAGE_RESET[PAGES-1:0];
    end else if (ctrl_write && ctrl_unlocked) begin
      if (lower_alias_unlock_reg) begin
        lower_page_protect_reg <= pwdata_in[boot_protect_pkg::LOWER_PAGE_LSB +: PAGES];
      end
      if (upper_alias_unlock_reg) begin
        upper_page_protect_reg <= pwdata_in[boot_protect_pkg::UPPER_PAGE_LSB +: PAGES];
      end
    end
  end

  // Read data register; unmapped addresses read zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_reg <= 32'h00000000;
    end else if (psel_in && !penable_in && !pwrite_in && clk_en_in) begin
      case (paddr_in)
        boot_protect_pkg::PROTECT_CTRL_OFFSET: begin
          prdata_reg <= ctrl_image(lower_alias_unlock_reg, upper_alias_unlock_reg,
                                   lower_page_protect_reg, upper_page_protect_reg);
        end
        boot_protect_pkg::CHECK_OFFSET: begin
          prdata_reg <= {31'h00000000, refused_reg};
        end
        default: begin
          prdata_reg <= 32'h00000000;
        end
      endcase
    end
  end

  // Sequencer check of the requested address
  assign map.lower_page_protect = lower_page_protect_reg;
  assign map.upper_page_protect = upper_page_protect_reg;
  page_guard u_page_guard (
    .addr_in(flash_op_addr_in),
    .map_in(map),
    .blocked_out(blocked)
  );
  assign flash_op_allow_out = flash_op_valid_in && !blocked;
  assign flash_op_refuse_out = flash_op_valid_in && blocked;

  // Sticky refusal status, set wins over the read clear
  // Clears only a flag the read captured, so a refusal during the setup cycle survives
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      refused_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (flash_op_valid_in && blocked) begin
        refused_reg <= 1'b1;
      end else if (rd_access && paddr_in == boot_protect_pkg::CHECK_OFFSET && prdata_reg[0]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // Registered protection map for the sequencer
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      lower_page_protect_out <= boot_protect_pkg::PAGE_RESET[PAGES-1:0];
      upper_page_protect_out <= boot_protect_pkg::PAGE_RESET[PAGES-1:0];
    end else if (clk_en_in) begin
      lower_page_protect_out <= lower_page_protect_reg;
      upper_page_protect_out <= upper_page_protect_reg;
    end
  end

  // Lower unlock never rises except by reset
  lower_sticky_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(lower_alias_unlock_reg) |-> !lower_alias_unlock_reg) else $error("lower unlock rose");
  // Upper unlock never rises except by reset
  upper_sticky_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(upper_alias_unlock_reg) |-> !upper_alias_unlock_reg) else $error("upper unlock rose");
  // Lower pages frozen when locked
  lower_frozen_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !lower_alias_unlock_reg |=> $stable(lower_page_protect_reg)) else $error("lower pages moved");
  // Upper pages frozen when locked
  upper_frozen_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !upper_alias_unlock_reg |=> $stable(upper_page_protect_reg)) else $error("upper pages moved");
  // Write without key leaves both page fields and the lower unlock bit unchanged
  keyless_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ctrl_write && !ctrl_unlocked |=> $stable(lower_page_protect_reg) && $stable(upper_page_protect_reg)
    && $stable(lower_alias_unlock_reg)) else $error("keyless write took");
  // Unlocked write lands in the lower page bits
  page_update_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ctrl_write && ctrl_unlocked && lower_alias_unlock_reg
    |=> lower_page_protect_reg == $past(pwdata_in[boot_protect_pkg::LOWER_PAGE_LSB +: PAGES]))
    else $error("page write lost");
  // Control read shows reserved one and unimplemented zero
  read_image_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    psel_in && !penable_in && !pwrite_in && clk_en_in && paddr_in == boot_protect_pkg::PROTECT_CTRL_OFFSET
    |=> prdata_out[boot_protect_pkg::TOOL_RESERVED_BIT] && prdata_out[31:16] == 16'h0000
    && prdata_out[14:13] == 2'b00 && !prdata_out[5]) else $error("bad read image");
  // Refused operation leaves the sticky flag set
  refuse_sticky_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    flash_op_valid_in && blocked && clk_en_in |=> refused_reg) else $error("refusal not recorded");
  // Protected upper page is refused
  upper_refuse_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    flash_op_valid_in && flash_op_addr_in == boot_protect_pkg::UPPER_ALIAS_BASE && upper_page_protect_reg[0]
    |-> flash_op_refuse_out && !flash_op_allow_out) else $error("upper page not refused");
  // Protected lower page is refused
  lower_refuse_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    flash_op_valid_in && flash_op_addr_in == boot_protect_pkg::LOWER_ALIAS_BASE && lower_page_protect_reg[0]
    |-> flash_op_refuse_out) else $error("lower page not refused");
endmodule // boot_page_write_protect

// ==== logic/boot_protect_pkg.sv ====
// Purpose: Shared constants and types for the boot page write-protect block
// Assumes: 32-bit APB register bus, word-aligned registers
// Notes: Register offsets of the key and status registers are local choices
package boot_protect_pkg;
  // Register byte offsets
  localparam logic [7:0] PROTECT_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] KEY_OFFSET = 8'h04;
  localparam logic [7:0] CHECK_OFFSET = 8'h08;
  // Control register field positions
  localparam int LOWER_UNLOCK_BIT = 15;
  localparam int LOWER_PAGE_LSB = 8;
  localparam int UPPER_UNLOCK_BIT = 7;
  localparam int TOOL_RESERVED_BIT = 6;
  localparam int UPPER_PAGE_LSB = 0;
  localparam int PAGES_PER_ALIAS = 5;
  // Reset values
  localparam logic [4:0] PAGE_RESET = 5'h1F;
  // Key unlock sequence words, values are arbitrary local choices
  localparam logic [31:0] KEY_WORD_FIRST = 32'hC35A0FF0;
  localparam logic [31:0] KEY_WORD_SECOND = 32'h0FF05AC3;
  // Page geometry: 16 KB pages
  localparam int PAGE_SHIFT = 14;
  localparam logic [31:0] LOWER_ALIAS_BASE = 32'h1FC00000;
  localparam logic [31:0] UPPER_ALIAS_BASE = 32'h1FC20000;
  localparam logic [31:0] ALIAS_SPAN = 32'h00014000;
  // Key sequence states
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } key_state_type;
  // Protection state carried to the checker
  typedef struct packed {
    logic [4:0] lower_page_protect;
    logic [4:0] upper_page_protect;
  } protect_map_type;
endpackage

// ==== logic/page_guard.sv ====
// Purpose: Decide whether a flash program/erase address hits a protected boot page
// Assumes: Addresses are physical byte addresses
// Notes: Purely combinational
`timescale 1ns/10ps
module page_guard (
  input wire logic [31:0] addr_in,
  input wire boot_protect_pkg::protect_map_type map_in,
  output logic blocked_out
);
  logic [31:0] lower_off;
  logic [31:0] upper_off;
  logic [31:0] lower_idx;
  logic [31:0] upper_idx;
  // Offset into each alias and page index inside it
  always_comb begin
    lower_off = addr_in - boot_protect_pkg::LOWER_ALIAS_BASE;
    upper_off = addr_in - boot_protect_pkg::UPPER_ALIAS_BASE;
    lower_idx = lower_off >> boot_protect_pkg::PAGE_SHIFT;
    upper_idx = upper_off >> boot_protect_pkg::PAGE_SHIFT;
    blocked_out = 1'b0;
    if (addr_in >= boot_protect_pkg::LOWER_ALIAS_BASE && lower_off < boot_protect_pkg::ALIAS_SPAN) begin
      blocked_out = map_in.lower_page_protect[lower_idx[2:0]];
    end
    if (addr_in >= boot_protect_pkg::UPPER_ALIAS_BASE && upper_off < boot_protect_pkg::ALIAS_SPAN) begin
      blocked_out = map_in.upper_page_protect[upper_idx[2:0]];
    end
  end
endmodule // page_guard

// ==== verification/boot_page_write_protect_bench.sv ====
// Purpose: Self-checking bench for the boot page write-protect block
// Assumes: Zero-wait APB slave, 40 MHz clock, synchronous active-high reset
// Notes: Driver notes each expected read or query result, a monitor compares them
`timescale 1ns/10ps
module boot_page_write_protect_bench;
  localparam logic [7:0] CTRL = boot_protect_pkg::PROTECT_CTRL_OFFSET;
  localparam logic [7:0] KEY = boot_protect_pkg::KEY_OFFSET;
  localparam logic [7:0] STAT = boot_protect_pkg::CHECK_OFFSET;
  logic sys_clk_in, rst_in, clk_en_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic flash_op_valid_in, flash_op_allow_out, flash_op_refuse_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, flash_op_addr_in, w, ctrl;
  logic [4:0] lower_page_protect_out, upper_page_protect_out;
  logic [31:0] exp_q[$];
  int errors, check_count;
  boot_page_write_protect u_boot_page_write_protect (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .flash_op_valid_in(flash_op_valid_in), .flash_op_addr_in(flash_op_addr_in),
    .flash_op_allow_out(flash_op_allow_out), .flash_op_refuse_out(flash_op_refuse_out),
    .lower_page_protect_out(lower_page_protect_out), .upper_page_protect_out(upper_page_protect_out));
  // Clock generator, 25 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Monitor: compares each completed read and each sequencer query with the oldest note
  always @(posedge sys_clk_in) begin
    if ((psel_in && penable_in && !pwrite_in && pready_out === 1'b1) || flash_op_valid_in) begin
      if (exp_q.size() == 0) begin
        check(32'hFFFFFFFF, 32'h0);
      end else begin
        check(flash_op_valid_in ? {30'h0, flash_op_allow_out, flash_op_refuse_out} : prdata_out, exp_q.pop_front());
      end
    end
  end
  // One APB transfer: setup, then access until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= data;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    check({31'h0, pslverr_out}, 32'h0);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, addr, 32'h0);
  endtask
  task automatic unlock();
    xfer(1'b1, KEY, boot_protect_pkg::KEY_WORD_FIRST);
    xfer(1'b1, KEY, boot_protect_pkg::KEY_WORD_SECOND);
  endtask
  task automatic probe(input logic [31:0] addr, input logic prot);
    exp_q.push_back(prot ? 32'h1 : 32'h2);
    flash_op_valid_in <= 1'b1;
    flash_op_addr_in <= addr;
    @(posedge sys_clk_in);
    flash_op_valid_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // Query one random address in every page of both aliases, then the outside space
  task automatic probe_pages(input logic [31:0] c);
    for (int i = 0; i < 5; i++) begin
      probe(boot_protect_pkg::LOWER_ALIAS_BASE + (32'(i) << 14) + ($urandom & 32'h3FFF), c[8+i]);
      probe(boot_protect_pkg::UPPER_ALIAS_BASE + (32'(i) << 14) + ($urandom & 32'h3FFF), c[i]);
    end
    probe(32'h1D000000, 1'b0);
    check({27'h0, lower_page_protect_out}, {27'h0, c[12:8]});
    check({27'h0, upper_page_protect_out}, {27'h0, c[4:0]});
  endtask
  task automatic end_of_test();
    if (exp_q.size() != 0) errors++;
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    errors = 0;
    check_count = 0;
    {rst_in, clk_en_in, psel_in, penable_in, pwrite_in, flash_op_valid_in} = 6'b110000;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    flash_op_addr_in = 32'h0;
    w = $urandom(50566);
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    ctrl = 32'h00009FDF;
    rd(CTRL, ctrl);
    rd(8'h0C, 32'h0);
    probe_pages(ctrl);
    rd(STAT, 32'h1);
    rd(STAT, 32'h0);
    $display("test reset_values done");
    xfer(1'b1, CTRL, 32'h0);
    xfer(1'b1, KEY, boot_protect_pkg::KEY_WORD_FIRST);
    xfer(1'b1, KEY, 32'h12345678);
    xfer(1'b1, CTRL, 32'h0);
    unlock();
    xfer(1'b1, STAT, 32'h0);
    xfer(1'b1, CTRL, 32'h0);
    rd(CTRL, ctrl);
    $display("test unkeyed_writes done");
    w = $urandom | 32'h00008080;
    unlock();
    xfer(1'b1, CTRL, w);
    ctrl = (w & 32'h00009F9F) | 32'h40;
    rd(CTRL, ctrl);
    probe_pages(ctrl);
    $display("test keyed_pages done");
    w = $urandom & 32'hFFFF7F7F;
    unlock();
    xfer(1'b1, CTRL, w);
    ctrl = (w & 32'h00001F1F) | 32'h40;
    rd(CTRL, ctrl);
    unlock();
    xfer(1'b1, CTRL, ~w);
    rd(CTRL, ctrl);
    probe_pages(ctrl);
    $display("test locked_aliases done");
    clk_en_in <= 1'b0;
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    clk_en_in <= 1'b1;
    ctrl = 32'h00009FDF;
    rd(CTRL, ctrl);
    clk_en_in <= 1'b0;
    unlock();
    xfer(1'b1, CTRL, 32'h0);
    clk_en_in <= 1'b1;
    rd(CTRL, ctrl);
    $display("test reset_and_enable done");
    repeat (2) @(posedge sys_clk_in);
    end_of_test();
  end
endmodule // boot_page_write_protect_bench
